// [include/lcdc_consts.svh]
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

// Register offsets on the local port (word index = address)
`define LCDC_OFS_CTRL        2'h0
`define LCDC_OFS_CTRL2       2'h1
`define LCDC_OFS_CKSTP2      2'h2

// Reset values
`define LCDC_CTRL_RST        8'h80
`define LCDC_CTRL2_RST       8'h60
`define LCDC_CKSTP2_RST      8'hff

// Field positions in the first control register
`define LCDC_CTRL_PSW        6
`define LCDC_CTRL_ACT        5
`define LCDC_CTRL_SHOW_RAM_DATA       4

// Field positions in the second control register
`define LCDC_CTRL2_AB        7
`define LCDC_CTRL2_DRIVE_SUPPLY_SELECT      4

// Field position in the clock stop register
`define LCDC_CKSTP2_LCD      0

// Bits that always read as one
`define LCDC_CTRL_FIXED      8'h80
`define LCDC_CTRL2_FIXED     8'h60
`define LCDC_CKSTP2_FIXED    8'hf0

// Frame timing in operating clock ticks
`define LCDC_FRAME_TICKS     8'hff
`define LCDC_FRAME3_TICKS    8'hbf
`define LCDC_STEP_TICKS      7'h40

`endif

// [include/lcdc_pkg.sv]
package lcdc_pkg;

  // Operating clock source, top bit of the frame clock field
  typedef enum logic [0:0] {
    LCDC_SRC_SUB = 1'b0,
    LCDC_SRC_SYS = 1'b1
  } lcdc_src_t;

  // Drive waveform family
  typedef enum logic [0:0] {
    LCDC_WAVE_A = 1'b0,
    LCDC_WAVE_B = 1'b1
  } lcdc_wave_t;

endpackage

// [logic/lcdc_chgpulse.sv]
`include "lcdc_consts.svh"

// Charge/discharge pulse for the split-resistor network
module lcdc_chgpulse (
  // Clock and reset
  input  logic       clk,
  input  logic       rst,
  // Control
  input  logic       run,
  input  logic       op_tick,
  input  logic [3:0] charge_pulse_duty_select,
  // Result
  output logic       charge_connect
);

  logic [4:0] phase_r;     // Position in the 32-tick pulse period
  logic       conn_nxt;    // Connection level for this phase
  logic       conn_r;      // Registered connection level

  // Duty decode against the pulse phase
  always_comb begin
    case (charge_pulse_duty_select)
      4'h0:    conn_nxt = 1'b1;
      4'h7:    conn_nxt = 1'b0;
      4'h8, 4'h9, 4'ha, 4'hb:
               conn_nxt = (phase_r[4:1] == 4'h0);
      4'hc, 4'hd, 4'he, 4'hf:
               conn_nxt = (phase_r == 5'h00);
      default: conn_nxt = ({1'b0, phase_r[4:2]} <
                           charge_pulse_duty_select);
    endcase
  end

  // Phase counter and output flop
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      phase_r <= 5'h00;
      conn_r  <= 1'b0;
    end else begin
      conn_r <= conn_nxt;
      if (op_tick) begin
        phase_r <= phase_r + 5'h01;
      end
    end
  end

  assign charge_connect = conn_r;

endmodule

// [logic/lcdc_ctrl.sv]
// Function
// - Activate bit low halts the controller
// - Activate low forces supply off, keeps registers
// - Sub-clock source divided by one, two, four
// - System source divided by two to 256
// - Halted system clock gives no display
// - Frame is 256 ticks of undivided sub-clock
// - One-third duty makes frames four thirds faster
// - Waveform bit selects A or B drive
// - Reserved second-register bits read one
// - Supply bit selects main supply or booster
// - Duty field sets charge pulse duty
// - Duty is connected time over pulse period
// - Duty code seven keeps network disconnected
// - Module stop bit low means standby
// - Second control register resets to 60 hex
// - Power switch enables supply, off in standby
// - First register resets 80 hex, top bit one

`include "lcdc_consts.svh"

// Register and drive control core of the LCD block.
// First control register layout:
//   bit 7 fixed one, bit 6 power switch, bit 5 activate,
//   bit 4 RAM data shown, bits 3..0 frame clock select.
// Second control register layout:
//   bit 7 waveform, bits 6..5 fixed one, bit 4 supply select,
//   bits 3..0 charge pulse duty select.
// Clock stop register layout:
//   bits 7..4 fixed one, bits 3..1 other modules, bit 0 this module.
// Clock stop bit 0 low puts this module in standby.
// Writes to fixed bits and to index 3 are dropped.
module lcdc_ctrl #(
  parameter int SYS_DIV_W = 8
) (
  // Clock and reset
  input  logic       clk,
  input  logic       rst,
  // Register port
  input  logic [1:0] reg_addr,
  input  logic [7:0] reg_wdata,
  input  logic       reg_wr,
  input  logic       reg_rd,
  output logic [7:0] reg_rdata,
  // Timing sources and chip state
  input  logic       sub_tick,
  input  logic       sys_halted,
  input  logic       chip_standby,
  input  logic       duty_third,
  // Drive outputs
  output logic       drive_enable,
  output logic       frame_strobe,
  output logic [1:0] com_index,
  output logic       drive_polarity,
  output logic       show_ram_data,
  output logic       waveform_type_select,
  // Supply outputs
  output logic       drive_supply_on,
  output logic       booster_run,
  output logic       charge_connect
);

  // Register storage
  // Fixed bits are not stored; they are merged on read
  logic [6:0] ctrl_r;           // First control register, bits 6..0
  logic       wave_r;           // Waveform select
  logic       drive_supply_select_r;           // Drive supply select
  logic [3:0] cds_r;            // Charge pulse duty select
  logic [3:0] ckstp_r;          // Clock stop bits 3..0
  logic [7:0] rdata_r;          // Read data register

  // Decoded fields
  logic       display_activate; // Controller activate
  logic       drive_power_switch; // Supply enable request
  logic       show_ram_bit;     // Display data bit
  logic [3:0] frame_clock_select; // Frame clock code
  logic       lcd_module_stop;  // Clear of module standby

  // Address decode
  logic       sel_ctrl;         // First control register hit
  logic       sel_ctrl2;        // Second control register hit
  logic       sel_ckstp;        // Clock stop register hit
  logic [7:0] rd_mux;           // Read value before the flop

  // Write enables
  logic       wr_ctrl;          // Write hits first control register
  logic       wr_ctrl2;         // Write hits second control register
  logic       wr_ckstp;         // Write hits clock stop register

  // Read words with fixed bits merged
  logic [7:0] rd_ctrl;          // First control register word
  logic [7:0] rd_ctrl2;         // Second control register word
  logic [7:0] rd_ckstp;         // Clock stop register word

  // Operating state
  logic       run;              // Module clock running
  logic       op_tick;          // Operating clock tick
  logic [7:0] tick_cnt_r;       // Position within a frame
  logic [7:0] tick_cnt_nxt;     // Next frame position
  logic [7:0] frame_last;       // Last tick of a frame
  logic       frame_end;        // Frame completes this tick
  logic       frame_par_r;      // Frame parity for B drive
  logic       pol_nxt;          // Next drive polarity
  logic [1:0] com_nxt;          // Common step for the next cycle

  // Registered drive outputs
  logic       frame_strobe_r;   // One-cycle frame strobe
  logic [1:0] com_index_r;      // Active common line
  logic       pol_r;            // Drive polarity
  logic       show_r;           // RAM data gate
  logic       drv_en_r;         // Drive enable
  logic       supply_r;         // Drive supply enable
  logic       boost_r;          // Booster run

  // Supply requests
  logic       supply_req;       // Drive supply wanted
  logic       boost_req;        // Booster wanted

  // Field extraction
  // Frame clock select: top bit picks sub or system clock
  assign drive_power_switch = ctrl_r[`LCDC_CTRL_PSW];
  assign display_activate   = ctrl_r[`LCDC_CTRL_ACT];
  assign show_ram_bit       = ctrl_r[`LCDC_CTRL_SHOW_RAM_DATA];
  assign frame_clock_select = ctrl_r[3:0];
  assign lcd_module_stop    = ckstp_r[`LCDC_CKSTP2_LCD];

  // Address decode
  assign sel_ctrl  = reg_addr == `LCDC_OFS_CTRL;
  assign sel_ctrl2 = reg_addr == `LCDC_OFS_CTRL2;
  assign sel_ckstp = reg_addr == `LCDC_OFS_CKSTP2;

  // Write enables; index 3 takes no write
  assign wr_ctrl  = reg_wr & sel_ctrl;
  assign wr_ctrl2 = reg_wr & sel_ctrl2;
  assign wr_ckstp = reg_wr & sel_ckstp;

  // Read words; fixed bits always read one
  assign rd_ctrl  = `LCDC_CTRL_FIXED | {1'b0, ctrl_r};
  assign rd_ctrl2 = `LCDC_CTRL2_FIXED |
                    {wave_r, 2'b00, drive_supply_select_r, cds_r};
  assign rd_ckstp = `LCDC_CKSTP2_FIXED | {4'h0, ckstp_r};

  // Read selection; unmapped index reads zero
  assign rd_mux = sel_ctrl  ? rd_ctrl  :
                  sel_ctrl2 ? rd_ctrl2 :
                  sel_ckstp ? rd_ckstp :
                  8'h00;

  // First control register; top bit is not stored
  // Frame clock changes take effect from the next clock; prescalers run on
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= 7'(`LCDC_CTRL_RST);
    end else if (wr_ctrl) begin                            // Software write
      ctrl_r <= reg_wdata[6:0];
    end
  end

  // Second control register; bits 6 and 5 not stored
  // Duty changes apply from the next clock; pulse phase runs on
  always_ff @(posedge clk) begin
    if (rst) begin
      wave_r <= 1'(`LCDC_CTRL2_RST >> `LCDC_CTRL2_AB);
      drive_supply_select_r <= 1'(`LCDC_CTRL2_RST >> `LCDC_CTRL2_DRIVE_SUPPLY_SELECT);
      cds_r  <= 4'(`LCDC_CTRL2_RST);
    end else if (wr_ctrl2) begin                           // Software write
      wave_r <= reg_wdata[`LCDC_CTRL2_AB];
      drive_supply_select_r <= reg_wdata[`LCDC_CTRL2_DRIVE_SUPPLY_SELECT];
      cds_r  <= reg_wdata[3:0];
    end
  end

  // Clock stop register; upper nibble reads one
  // Bits 3..1 belong to other modules: stored, drive nothing here
  always_ff @(posedge clk) begin
    if (rst) begin
      ckstp_r <= 4'(`LCDC_CKSTP2_RST);
    end else if (wr_ckstp) begin                           // Software write
      ckstp_r <= reg_wdata[3:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  // Zero otherwise, so a stale word never looks like an answer
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // Module runs only when activated and out of standby
  // Registers survive a halt; only counters and drive flops clear
  assign run = display_activate
             & lcd_module_stop;

  // Operating clock tick from the selected source
  // Prescalers sit in reset while the module clock is gated
  lcdc_tickgen #(
    .SYS_DIV_W (SYS_DIV_W)
  ) u_tickgen (
    .clk                (clk),
    .rst                (rst),
    .run                (run),
    .frame_clock_select (frame_clock_select),
    .sub_tick           (sub_tick),
    .sys_halted         (sys_halted),
    .op_tick            (op_tick)
  );

  // Frame length: 256 ticks, or 192 at one-third duty
  // Four common steps of 64 ticks, or three at one-third duty
  assign frame_last = duty_third ? `LCDC_FRAME3_TICKS
                                 : `LCDC_FRAME_TICKS;
  assign frame_end  = op_tick && (tick_cnt_r == frame_last);

  // Frame position advance
  // Wraps to zero on the last tick of a frame
  assign tick_cnt_nxt = frame_end ? 8'h00 : tick_cnt_r + 8'h01;

  // A drive flips every 32 ticks, inside each common step;
  // B drive holds one polarity per frame and flips at frame end
  assign pol_nxt = (wave_r == lcdc_pkg::LCDC_WAVE_B) ?
                   frame_par_r : tick_cnt_r[5];

  // Common step follows the top bits of the frame position
  assign com_nxt = tick_cnt_r[7:6];

  // Frame counter, cleared while the module clock is gated
  // Selecting one-third duty past tick 191 runs on to 255 and wraps:
  // one long frame, never a hang
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      tick_cnt_r  <= 8'h00;
      frame_par_r <= 1'b0;
    end else if (op_tick) begin
      tick_cnt_r <= tick_cnt_nxt;
      if (frame_end) begin
        frame_par_r <= ~frame_par_r;
      end
    end
  end

  // Drive outputs, all quiet while halted
  // Launched one cycle after the frame position they describe
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      frame_strobe_r <= 1'b0;
      com_index_r    <= 2'h0;
      pol_r          <= 1'b0;
      show_r         <= 1'b0;
      drv_en_r       <= 1'b0;
    end else begin
      frame_strobe_r <= frame_end;
      com_index_r    <= com_nxt;
      pol_r          <= pol_nxt;
      show_r         <= show_ram_bit;
      drv_en_r       <= 1'b1;
    end
  end

  // Supply wanted only when active, switched on, out of standby
  assign supply_req = run & drive_power_switch
                    & ~chip_standby;
  // Booster runs only under a live supply with the boost select set
  assign boost_req  = supply_req & drive_supply_select_r;

  // Supply control flops
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_r <= 1'b0;                                    // Supply off
      boost_r  <= 1'b0;                                    // Booster off
    end else begin
      supply_r <= supply_req;
      boost_r  <= boost_req;
    end
  end

  // Charge/discharge pulse generator
  // Pulse period is 32 operating ticks; connection off while halted
  lcdc_chgpulse u_chgpulse (
    .clk                      (clk),
    .rst                      (rst),
    .run                      (run),
    .op_tick                  (op_tick),
    .charge_pulse_duty_select (cds_r),
    .charge_connect           (charge_connect)
  );

  // Output assignments
  // Every data output comes straight from a flop
  assign drive_enable         = drv_en_r;
  assign frame_strobe         = frame_strobe_r;
  assign com_index            = com_index_r;
  assign drive_polarity       = pol_r;
  assign show_ram_data        = show_r;
  assign waveform_type_select = wave_r;
  assign drive_supply_on      = supply_r;
  assign booster_run          = boost_r;

endmodule

// [logic/lcdc_tickgen.sv]
`include "lcdc_consts.svh"

// Operating clock tick generator for the frame logic
module lcdc_tickgen #(
  parameter int SYS_DIV_W = 8
) (
  // Clock and reset
  input  logic       clk,
  input  logic       rst,
  // Control
  input  logic       run,
  input  logic [3:0] frame_clock_select,
  input  logic       sub_tick,
  input  logic       sys_halted,
  // Result
  output logic       op_tick
);

  logic [SYS_DIV_W-1:0] sys_cnt_r;   // System clock prescaler
  logic [1:0]           sub_cnt_r;   // Sub-clock prescaler
  logic [SYS_DIV_W-1:0] sys_mask;    // Ones above the selected width
  logic                 sys_tick;    // Divided system clock tick
  logic                 sub_sel_tick;// Divided sub-clock tick
  logic                 use_sys;     // Source is system clock

  assign use_sys = frame_clock_select[3] == lcdc_pkg::LCDC_SRC_SYS;

  // Mask out the high bits; low (code+1) bits must all be one
  genvar g;
  generate
    for (g = 0; g < SYS_DIV_W; g++) begin : g_mask
      assign sys_mask[g] = (g > frame_clock_select[2:0]);
    end
  endgenerate

  // Halted system clock yields no ticks at all
  assign sys_tick = (&(sys_cnt_r | sys_mask)) & ~sys_halted;

  // Sub-clock: 00 undivided, 01 halved, 1x quartered
  assign sub_sel_tick = frame_clock_select[1] ?
                        (sub_tick & (&sub_cnt_r)) :
                        frame_clock_select[0] ?
                        (sub_tick & sub_cnt_r[0]) : sub_tick;

  assign op_tick = run & (use_sys ? sys_tick : sub_sel_tick);

  // Prescalers, held in reset while the module is idle
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      sys_cnt_r <= '0;
      sub_cnt_r <= 2'h0;
    end else begin
      if (!sys_halted) begin
        sys_cnt_r <= sys_cnt_r + 1'b1;
      end
      if (sub_tick) begin
        sub_cnt_r <= sub_cnt_r + 2'h1;
      end
    end
  end

endmodule

// [testbench/lcdc_ctrl_chk.sv]
`include "lcdc_consts.svh"

// Port-level checker for the LCD control block
module lcdc_ctrl_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Chip state and outputs
  input wire logic       chip_standby,
  input wire logic       drive_enable,
  input wire logic       frame_strobe,
  input wire logic [1:0] com_index,
  input wire logic       drive_supply_on,
  input wire logic       booster_run,
  input wire logic       charge_connect
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_ctrl_top_one: assert property (
    reg_rd && reg_addr == `LCDC_OFS_CTRL |=> reg_rdata[7])
    else $error("ctrl top bit read low");
  a_ctrl2_fixed_ones: assert property (
    reg_rd && reg_addr == `LCDC_OFS_CTRL2 |=> reg_rdata[6:5] == 2'h3)
    else $error("ctrl2 reserved bits read low");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 2'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_booster_gate: assert property (
    booster_run |-> drive_supply_on)
    else $error("booster runs without supply");
  a_standby_off: assert property (
    chip_standby |=> !drive_supply_on)
    else $error("supply on in standby");
  a_halt_supply: assert property (
    !drive_enable |-> !drive_supply_on)
    else $error("supply on while halted");
  a_frame_pulse: assert property (
    frame_strobe |=> !frame_strobe [*8])
    else $error("frame strobes too close");
  a_halt_clear: assert property (
    !drive_enable [*2] |-> com_index == 2'h0 && !frame_strobe)
    else $error("drive active while halted");
  a_halt_charge: assert property (
    !drive_enable [*2] |-> !charge_connect)
    else $error("charge pulse while halted");
endmodule

bind lcdc_ctrl lcdc_ctrl_chk u_lcdc_ctrl_chk (
  .clk             (clk),
  .rst             (rst),
  .reg_addr        (reg_addr),
  .reg_rd          (reg_rd),
  .reg_rdata       (reg_rdata),
  .chip_standby    (chip_standby),
  .drive_enable    (drive_enable),
  .frame_strobe    (frame_strobe),
  .com_index       (com_index),
  .drive_supply_on (drive_supply_on),
  .booster_run     (booster_run),
  .charge_connect  (charge_connect)
);

// [testbench/lcdc_ctrl_tb.sv]
module lcdc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        sub_tick = 1'b0;
  logic        sys_halted = 1'b0;
  logic        chip_standby = 1'b0;
  logic        duty_third = 1'b0;
  logic        drive_enable, frame_strobe, drive_polarity;
  logic [1:0]  com_index;
  logic        show_ram_data, waveform_type_select;
  logic        drive_supply_on, booster_run, charge_connect;
  logic [15:0] frame_cnt;
  logic        ext_bias_on;
  logic [31:0] seed = 32'h5;
  logic [7:0]  v;
  logic [1:0]  sub_div = 2'h0;
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'h9};
  int          num_errors = 0;
  int          check_count = 0;

  always #5 clk = ~clk;

  // Watch sub-clock: one pulse every four clocks
  always @(posedge clk) begin
    sub_div <= sub_div + 2'h1;
    sub_tick <= (sub_div == 2'h3);
  end

  lcdc_ctrl u_lcdc_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sub_tick(sub_tick), .sys_halted(sys_halted),
    .chip_standby(chip_standby), .duty_third(duty_third),
    .drive_enable(drive_enable), .frame_strobe(frame_strobe),
    .com_index(com_index), .drive_polarity(drive_polarity),
    .show_ram_data(show_ram_data),
    .waveform_type_select(waveform_type_select),
    .drive_supply_on(drive_supply_on), .booster_run(booster_run),
    .charge_connect(charge_connect));

  lcdc_panel u_lcdc_panel (.clk(clk), .rst(rst),
    .drive_enable(drive_enable),
    .frame_strobe(frame_strobe), .charge_connect(charge_connect),
    .frame_cnt(frame_cnt), .ext_bias_on(ext_bias_on));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Frame length in clocks, sub tick every four clocks
  function automatic int exp_period(input logic [3:0] c, input logic t);
    int tk;
    tk = t ? 192 : 256;
    if (c[3]) return tk << (c[2:0] + 1);
    return tk * 4 * (c[1] ? 4 : (c[0] ? 2 : 1));
  endfunction

  // High clocks in one 32-tick pulse period
  function automatic int exp_high(input logic [3:0] c);
    if (c == 4'h0) return 128;
    if (c == 4'h7) return 0;
    if (c[3]) return c[2] ? 4 : 8;
    return c * 16;
  endfunction

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // Register write, one idle cycle after
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask

  // Clocks between two frame strobes
  task automatic period(output int n);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin @(posedge clk); #1; n++; end
      while (!frame_strobe && n < 70000);
    end
    @(posedge clk);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #800000;
    num_errors++;
    final_report();
  end

  initial begin
    int n;
    logic [15:0] f0;
    logic p;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and the unmapped index
    rd(2'h0, v); check("ctrl", 8'h80, v);
    rd(2'h1, v); check("ctrl2", 8'h60, v);
    rd(2'h2, v); check("ckstp", 8'hff, v);
    rd(2'h3, v); check("unmapped", 8'h00, v);
    // Random settings with standby toggling
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      chip_standby <= seed[20];
      wr(2'h0, seed[15:8]);
      wr(2'h1, seed[7:0]);
      wr(2'h2, seed[23:16]);
      wr(2'h3, seed[31:24]);
      rd(2'h0, v); check("ctrl rb", seed[15:8] | 8'h80, v);
      rd(2'h1, v); check("ctrl2 rb", seed[7:0] | 8'h60, v);
      rd(2'h2, v); check("ckstp rb", seed[23:16] | 8'hf0, v);
      check("wave", seed[7], waveform_type_select);
      check("run", seed[13] & seed[16], drive_enable);
      check("show", seed[12] & seed[13] & seed[16],
            show_ram_data);
      n = seed[14] & seed[13] & seed[16] & !seed[20];
      check("supply", n, drive_supply_on);
      check("boost", n & seed[4], booster_run);
    end
    chip_standby <= 1'b0;
    wr(2'h2, 8'hff);
    wr(2'h1, 8'h00);
    // Frame length for six clock selection codes
    foreach (codes[i]) begin
      wr(2'h0, 8'h70 | codes[i]);
      period(n);
      check("frame", exp_period(codes[i], 1'b0), n);
    end
    duty_third <= 1'b1;
    wr(2'h0, 8'h70);
    period(n);
    check("frame3", exp_period(4'h0, 1'b1), n);
    duty_third <= 1'b0;
    // Polarity reversals per 1024-clock frame: eight for A, one for B
    for (int w = 0; w < 2; w++) begin
      wr(2'h1, {w[0], 7'h00});
      repeat (8) @(posedge clk);
      #1 p = drive_polarity;
      n = 0;
      repeat (1024) begin
        @(posedge clk);
        #1 n += (drive_polarity != p);
        p = drive_polarity;
      end
      check("polarity", w ? 1 : 8, n);
    end
    // System source with the system clock halted
    wr(2'h0, 8'h78);
    sys_halted <= 1'b1;
    repeat (600) @(posedge clk);
    f0 = frame_cnt;
    repeat (2000) @(posedge clk);
    check("halted", f0, frame_cnt);
    sys_halted <= 1'b0;
    // Module standby keeps registers, stops frames
    wr(2'h0, 8'h70);
    wr(2'h2, 8'hfe);
    f0 = frame_cnt;
    repeat (2000) @(posedge clk);
    check("stopped", f0, frame_cnt);
    rd(2'h0, v); check("kept", 8'hf0, v);
    wr(2'h2, 8'hff);
    // Charge pulse duty for every code
    for (int c = 0; c < 16; c++) begin
      wr(2'h1, c[7:0]);
      repeat (256) @(posedge clk);
      n = 0;
      repeat (128) begin @(posedge clk); #1; n += charge_connect; end
      @(posedge clk);
      check("charge", exp_high(c[3:0]), n);
      if (c == 7) check("ext bias", 1, ext_bias_on);
    end
    final_report();
  end
endmodule

// [testbench/lcdc_panel.sv]
// Panel electrodes: count frames scanned, note external bias need
module lcdc_panel (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Drive side of the block
  input  wire logic   drive_enable,
  input  wire logic   frame_strobe,
  input  wire logic   charge_connect,
  // Observations for the bench
  output logic [15:0] frame_cnt,
  output logic        ext_bias_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // One count per frame the panel actually sees
  always @(posedge clk) begin
    if (rst) begin
      frame_cnt <= 16'h0000;
    end else if (drive_enable && frame_strobe) begin
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end
  // Bias pins fed externally while the network stays off
  assign ext_bias_on = drive_enable && !charge_connect;
endmodule
